// [uc2_pkg.sv]
// constants and types shared by the serial port control block
package uc2_pkg;
   // register word indexes; byte address is index times four
   localparam logic [7:0] CTRL_IDX  = 8'h03;
   localparam logic [7:0] CFG_IDX   = 8'h08;
   localparam logic [7:0] STAT_IDX  = 8'h09;
   localparam logic [7:0] DATA_IDX  = 8'h0a;
   localparam int         ADDR_LSB  = 2;
   localparam logic [7:0] CTRL_RST  = 8'h00;
   localparam logic [5:0] CFG_RST   = 6'h00;
   // serial_control_two fields
   localparam int B_TXE  = 7;
   localparam int B_TXD  = 6;
   localparam int B_RXF  = 5;
   localparam int B_QL   = 4;
   localparam int B_TXON = 3;
   localparam int B_RXON = 2;
   localparam int B_STBY = 1;
   localparam int B_BRK  = 0;
   // configuration fields
   localparam int C_LOOP = 0;
   localparam int C_RX_INPUT_SEL = 1;
   localparam int C_DIR  = 2;
   localparam int C_LBRK = 3;
   localparam int C_NINE = 4;
   localparam int C_WAKE = 5;
   // status fields share the interrupt enable positions
   localparam int S_TXE  = 7;
   localparam int S_TXD  = 6;
   localparam int S_RXF  = 5;
   localparam int S_QL   = 4;
   // character lengths in bit times
   localparam logic [3:0] FRAME_BITS = 4'ha;
   localparam logic [3:0] BRK_BITS   = 4'ha;
   localparam logic [3:0] LBRK_BITS  = 4'hd;
   // timing
   localparam int CLK_HZ      = 20000000;
   localparam int BAUD_DEF    = 9600;
   localparam int BIT_CYC_DEF = CLK_HZ / BAUD_DEF;
   typedef enum logic [3:0] {
      TX_IDLE  = 4'h1,
      TX_FRAME = 4'h2,
      TX_PRE   = 4'h4,
      TX_BRK   = 4'h8
   } uc2_tx_st_t;
endpackage : uc2_pkg

// [uc2_rx_if.sv]
// bundle between the control logic and the receive shifter
`timescale 1ns/1ps
`default_nettype none
interface uc2_rx_if;
   logic       rx_line;
   logic       enable;
   logic       nine;
   logic [8:0] data;
   logic       done;
   logic       idle;
   modport rcv (input rx_line, input enable, input nine, output data, output done, output idle);
   modport ctl (output rx_line, output enable, output nine, input data, input done, input idle);
endinterface : uc2_rx_if
`default_nettype wire

// [uc2_rx.sv]
// receive shifter with quiet line detection
`timescale 1ns/1ps
`default_nettype none
module uc2_rx #(
   parameter int BIT_CYCLES = uc2_pkg::BIT_CYC_DEF
) (
   input  wire logic pclk,    // bus clock
   input  wire logic presetn, // async reset, low
   uc2_rx_if.rcv     bus      // control side
);
   typedef struct packed {
      logic        busy;
      logic [15:0] cyc;
      logic [3:0]  bitn;
      logic [8:0]  shf;
      logic [19:0] hi_cnt;
      logic        armed;
      logic [8:0]  data;
      logic        done;
      logic        idle;
   } uc2_rx_st_t;

   uc2_rx_st_t s;
   uc2_rx_st_t n;
   logic [19:0] idle_len;
   logic [3:0]  last_bit;

   generate
      if (BIT_CYCLES < 4 || BIT_CYCLES > 65535)
      begin : g_bad
         $error("uc2_rx: BIT_CYCLES out of range");
      end
   endgenerate

   always_comb
   begin
      n = s;
      n.done = 1'b0;
      n.idle = 1'b0;
      // quiet time counts only after a character, so reset alone raises no quiet event
      idle_len = bus.nine ? 20'((uc2_pkg::FRAME_BITS + 1) * BIT_CYCLES)
                          : 20'(uc2_pkg::FRAME_BITS * BIT_CYCLES);
      last_bit = bus.nine ? uc2_pkg::FRAME_BITS : uc2_pkg::FRAME_BITS - 4'h1;
      if (!bus.enable)
      begin
         n = '0;
         n.data = s.data;
      end
      else if (!s.busy)
      begin
         if (bus.rx_line)
         begin
            if (s.armed && s.hi_cnt == idle_len - 20'h00001)
            begin
               n.idle  = 1'b1;
               n.armed = 1'b0;
               n.hi_cnt = '0;
            end
            else if (s.armed)
               n.hi_cnt = s.hi_cnt + 20'h00001;
         end
         else
         begin
            n.busy   = 1'b1;
            n.cyc    = 16'(BIT_CYCLES / 2);
            n.bitn   = 4'h0;
            n.hi_cnt = '0;
         end
      end
      else if (s.cyc != 16'h0000)
         n.cyc = s.cyc - 16'h0001;
      else
      begin
         n.cyc  = 16'(BIT_CYCLES - 1);
         n.bitn = s.bitn + 4'h1;
         if (s.bitn == 4'h0 && bus.rx_line)
            n.busy = 1'b0;                       // false start
         else if (s.bitn == last_bit)
         begin
            n.busy  = 1'b0;
            n.done  = 1'b1;
            n.armed = 1'b1;
            n.data  = bus.nine ? s.shf : {1'b0, s.shf[8:1]};
         end
         else if (s.bitn != 4'h0)
            n.shf = {bus.rx_line, s.shf[8:1]};
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         s <= '0;
      else
         s <= n;
   end

   assign bus.data = s.data;
   assign bus.done = s.done;
   assign bus.idle = s.idle;
endmodule : uc2_rx
`default_nettype wire

// [uc2_top.sv]
// serial port second control register with transmitter, pin control and wakeup
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module uc2_top #(
   parameter int AW         = 12,
   parameter int BIT_CYCLES = uc2_pkg::BIT_CYC_DEF
) (
   input  wire logic          pclk,        // bus clock
   input  wire logic          presetn,     // async reset, low
   input  wire logic          psel,        // apb select
   input  wire logic          penable,     // apb enable
   input  wire logic          pwrite,      // apb direction
   input  wire logic [AW-1:0] paddr,       // apb byte address
   input  wire logic [31:0]   pwdata,      // apb write data
   output logic      [31:0]   prdata,      // apb read data
   output logic               pready,      // apb ready
   output logic               pslverr,     // apb error
   output logic               irq,         // interrupt request level
   input  wire logic          txd_in,      // transmit pin sensed
   output logic               txd_out,     // transmit pin driven value
   output logic               txd_oe_n,    // transmit pin enable, low drives
   output logic               tx_pin_own,  // port owns transmit pin
   input  wire logic          rxd_in,      // receive pin
   output logic               rxd_pin_own  // port owns receive pin
);
   typedef struct packed {
      logic [7:0]          ctrl;
      logic [5:0]          cfg;
      logic [8:0]          txb;
      logic                txe;
      logic [8:0]          rxb;
      logic                rxf;
      logic                ql;
      logic                idle_pend;
      logic                brk_pend;
      uc2_pkg::uc2_tx_st_t st;
      logic [15:0]         cyc;
      logic [3:0]          bitn;
      logic [10:0]         shf;
      logic                tx_line;
      logic [31:0]         prdata;
   } uc2_state_t;

   uc2_state_t s;
   uc2_state_t n;
   uc2_rx_if   rxb ();

   logic setup;
   logic wr;
   logic rd;
   logic mapped;
   logic [AW-3:0] widx;
   logic tc;
   logic single;
   logic fill;
   logic msb;
   logic [31:0] rdval;

   generate
      if (AW < 6 || BIT_CYCLES < 4 || BIT_CYCLES > 65535)
      begin : g_bad
         $error("uc2_top: parameter out of range");
      end
   endgenerate

   uc2_rx #(
      .BIT_CYCLES (BIT_CYCLES)
   ) uc2_rx_i (
      .pclk    (pclk),
      .presetn (presetn),
      .bus     (rxb)
   );

   // bus decode; zero wait states so every access ends in its first access cycle
   assign widx    = paddr[AW-1:uc2_pkg::ADDR_LSB];
   assign mapped  = (paddr[1:0] == 2'h0)
                    && (widx == (AW-2)'(uc2_pkg::CTRL_IDX) || widx == (AW-2)'(uc2_pkg::CFG_IDX)
                     || widx == (AW-2)'(uc2_pkg::STAT_IDX) || widx == (AW-2)'(uc2_pkg::DATA_IDX));
   assign setup   = psel && !penable;
   assign wr      = psel && penable && pwrite && mapped;
   assign rd      = psel && penable && !pwrite && mapped;
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;

   assign single = s.cfg[uc2_pkg::C_LOOP] && s.cfg[uc2_pkg::C_RX_INPUT_SEL];
   assign tc     = s.txe && s.st == uc2_pkg::TX_IDLE && !s.idle_pend && !s.brk_pend;

   // receiver input routing
   always_comb
   begin
      if (!s.cfg[uc2_pkg::C_LOOP])
         rxb.rx_line = rxd_in;
      else if (s.cfg[uc2_pkg::C_RX_INPUT_SEL])
         rxb.rx_line = s.cfg[uc2_pkg::C_DIR] ? s.tx_line : txd_in;
      else
         rxb.rx_line = s.tx_line;
   end
   assign rxb.enable = s.ctrl[uc2_pkg::B_RXON];
   assign rxb.nine   = s.cfg[uc2_pkg::C_NINE];
   assign msb        = s.cfg[uc2_pkg::C_NINE] ? rxb.data[8] : rxb.data[7];

   always_comb
   begin
      rdval = '0;
      if (widx == (AW-2)'(uc2_pkg::CTRL_IDX))
         rdval[7:0] = s.ctrl;
      else if (widx == (AW-2)'(uc2_pkg::CFG_IDX))
         rdval[5:0] = s.cfg;
      else if (widx == (AW-2)'(uc2_pkg::STAT_IDX))
      begin
         rdval[uc2_pkg::S_TXE] = s.txe;
         rdval[uc2_pkg::S_TXD] = tc;
         rdval[uc2_pkg::S_RXF] = s.rxf;
         rdval[uc2_pkg::S_QL]  = s.ql;
      end
      else if (widx == (AW-2)'(uc2_pkg::DATA_IDX))
         rdval[8:0] = s.rxb;
   end

   always_comb
   begin
      n = s;
      fill = s.st != uc2_pkg::TX_BRK;
      if (setup && !pwrite)
         n.prdata = rdval;

      // receiver side: clears first so a same-cycle set wins
      if (rd && widx == (AW-2)'(uc2_pkg::DATA_IDX))
      begin
         n.rxf = 1'b0;
         n.ql  = 1'b0;
      end
      // standby drops ordinary characters and quiet events until the wakeup
      if (s.ctrl[uc2_pkg::B_STBY])
      begin
         if (!s.cfg[uc2_pkg::C_WAKE] && rxb.idle)
            n.ctrl[uc2_pkg::B_STBY] = 1'b0;
         if (s.cfg[uc2_pkg::C_WAKE] && rxb.done && msb)
         begin
            n.ctrl[uc2_pkg::B_STBY] = 1'b0;
            n.rxb = rxb.data;
            n.rxf = 1'b1;
         end
      end
      else
      begin
         if (rxb.done)
         begin
            n.rxb = rxb.data;
            n.rxf = 1'b1;
         end
         if (rxb.idle)
            n.ql = 1'b1;
      end

      // transmitter
      case (s.st)
         uc2_pkg::TX_IDLE:
         begin
            n.cyc = 16'(BIT_CYCLES - 1);
            if (s.brk_pend)
            begin
               n.st       = uc2_pkg::TX_BRK;
               n.brk_pend = 1'b0;
               n.shf      = '0;
               n.bitn     = (s.cfg[uc2_pkg::C_LBRK] ? uc2_pkg::LBRK_BITS : uc2_pkg::BRK_BITS)
                            + {3'h0, s.cfg[uc2_pkg::C_NINE]};
            end
            else if (s.idle_pend)
            begin
               n.st        = uc2_pkg::TX_PRE;
               n.idle_pend = 1'b0;
               n.shf       = '1;
               n.bitn      = uc2_pkg::FRAME_BITS + {3'h0, s.cfg[uc2_pkg::C_NINE]};
            end
            else if (!s.txe)
            begin
               n.st  = uc2_pkg::TX_FRAME;
               n.txe = 1'b1;
               n.shf = s.cfg[uc2_pkg::C_NINE] ? {1'b1, s.txb, 1'b0}
                                              : {2'h3, s.txb[7:0], 1'b0};
               n.bitn = uc2_pkg::FRAME_BITS + {3'h0, s.cfg[uc2_pkg::C_NINE]};
            end
         end
         uc2_pkg::TX_FRAME, uc2_pkg::TX_PRE, uc2_pkg::TX_BRK:
         begin
            if (s.cyc != 16'h0000)
               n.cyc = s.cyc - 16'h0001;
            else
            begin
               n.cyc  = 16'(BIT_CYCLES - 1);
               n.shf  = {fill, s.shf[10:1]};
               n.bitn = s.bitn - 4'h1;
               if (s.bitn == 4'h1)
               begin
                  // a held break reloads in place so the line never blips high
                  if (s.st == uc2_pkg::TX_BRK && s.ctrl[uc2_pkg::B_BRK]
                      && s.ctrl[uc2_pkg::B_TXON])
                     n.bitn = (s.cfg[uc2_pkg::C_LBRK] ? uc2_pkg::LBRK_BITS
                                                      : uc2_pkg::BRK_BITS)
                              + {3'h0, s.cfg[uc2_pkg::C_NINE]};
                  else
                     n.st = uc2_pkg::TX_IDLE;
               end
            end
         end
         default:
            n.st = uc2_pkg::TX_IDLE;
      endcase

      // software writes come last; a standby set beats a same-cycle wakeup
      if (wr && widx == (AW-2)'(uc2_pkg::CTRL_IDX))
      begin
         n.ctrl = pwdata[7:0];
         if (!s.ctrl[uc2_pkg::B_TXON] && pwdata[uc2_pkg::B_TXON])
            n.idle_pend = 1'b1;
         if (!s.ctrl[uc2_pkg::B_BRK] && pwdata[uc2_pkg::B_BRK] && pwdata[uc2_pkg::B_TXON])
            n.brk_pend = 1'b1;
      end
      if (wr && widx == (AW-2)'(uc2_pkg::CFG_IDX))
         n.cfg = pwdata[5:0];
      if (wr && widx == (AW-2)'(uc2_pkg::DATA_IDX) && s.ctrl[uc2_pkg::B_TXON])
      begin
         n.txb = pwdata[8:0];
         n.txe = 1'b0;
      end
      n.tx_line = (n.st == uc2_pkg::TX_IDLE) ? 1'b1 : n.shf[0];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s           <= '0;
         s.ctrl      <= uc2_pkg::CTRL_RST;
         s.cfg       <= uc2_pkg::CFG_RST;
         s.txe       <= 1'b1;
         s.st        <= uc2_pkg::TX_IDLE;
         s.tx_line   <= 1'b1;
      end
      else
         s <= n;
   end

   assign prdata = s.prdata;

   // level request, held while any enabled flag stays set
   assign irq = (s.ctrl[uc2_pkg::B_TXE] && s.txe)
             || (s.ctrl[uc2_pkg::B_TXD] && tc)
             || (s.ctrl[uc2_pkg::B_RXF] && s.rxf)
             || (s.ctrl[uc2_pkg::B_QL]  && s.ql);

   // pin held through anything still queued after tx_on drops
   assign tx_pin_own  = s.ctrl[uc2_pkg::B_TXON] || s.st != uc2_pkg::TX_IDLE
                        || s.idle_pend || s.brk_pend || !s.txe;
   assign txd_out     = s.tx_line;
   assign txd_oe_n    = !(tx_pin_own && !(single && !s.cfg[uc2_pkg::C_DIR]));
   assign rxd_pin_own = s.ctrl[uc2_pkg::B_RXON] && !s.cfg[uc2_pkg::C_LOOP];

   AST_TXE_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
      (s.ctrl[uc2_pkg::B_TXE] && s.txe) |-> irq)
      else $error("tx empty enabled but no interrupt");
   AST_TXD_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
      (s.ctrl[uc2_pkg::B_TXD] && s.txe && s.st == uc2_pkg::TX_IDLE
       && !s.idle_pend && !s.brk_pend) |-> irq)
      else $error("tx done enabled but no interrupt");
   AST_RXF_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
      (s.ctrl[uc2_pkg::B_RXF] && rxb.done && !s.ctrl[uc2_pkg::B_STBY]
       && !(wr && widx == (AW-2)'(uc2_pkg::CTRL_IDX))) |=> irq)
      else $error("rx full enabled but no interrupt");
   AST_QL_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
      (s.ctrl[uc2_pkg::B_QL] && s.ql) |-> irq)
      else $error("quiet line enabled but no interrupt");
   AST_IRQ_OFF: assert property (@(posedge pclk) disable iff (!presetn)
      (s.ctrl[7:4] == 4'h0) |-> !irq)
      else $error("interrupt with all enables clear");
   AST_TX_DRIVE: assert property (@(posedge pclk) disable iff (!presetn)
      (s.ctrl[uc2_pkg::B_TXON] && !single) |-> !txd_oe_n)
      else $error("tx_on set but pin not driven");
   AST_SINGLE_RX: assert property (@(posedge pclk) disable iff (!presetn)
      (single && !s.cfg[uc2_pkg::C_DIR]) |-> txd_oe_n)
      else $error("single wire receive but pin driven");
   AST_IDLE_Q: assert property (@(posedge pclk) disable iff (!presetn)
      (wr && widx == (AW-2)'(uc2_pkg::CTRL_IDX) && !s.ctrl[uc2_pkg::B_TXON]
       && pwdata[uc2_pkg::B_TXON] && s.st != uc2_pkg::TX_IDLE) |=> s.idle_pend)
      else $error("idle character not queued");
   AST_HOLD_PIN: assert property (@(posedge pclk) disable iff (!presetn)
      (s.st != uc2_pkg::TX_IDLE || s.brk_pend) |-> tx_pin_own)
      else $error("pin released while transmitting");
   AST_LOOP_RX: assert property (@(posedge pclk) disable iff (!presetn)
      s.cfg[uc2_pkg::C_LOOP] |-> !rxd_pin_own)
      else $error("receive pin kept in loopback");
   AST_RX_OFF: assert property (@(posedge pclk) disable iff (!presetn)
      !s.ctrl[uc2_pkg::B_RXON] |-> !rxd_pin_own)
      else $error("receive pin kept with receiver off");
   AST_STBY_SET: assert property (@(posedge pclk) disable iff (!presetn)
      (wr && widx == (AW-2)'(uc2_pkg::CTRL_IDX) && pwdata[uc2_pkg::B_STBY])
      |=> s.ctrl[uc2_pkg::B_STBY])
      else $error("standby not entered on write");
   AST_MARK_WAKE: assert property (@(posedge pclk) disable iff (!presetn)
      (s.ctrl[uc2_pkg::B_STBY] && s.cfg[uc2_pkg::C_WAKE] && rxb.done && msb
       && !(wr && widx == (AW-2)'(uc2_pkg::CTRL_IDX))) |=> !s.ctrl[uc2_pkg::B_STBY])
      else $error("standby not cleared on address mark");
   AST_WAKE: assert property (@(posedge pclk) disable iff (!presetn)
      (s.ctrl[uc2_pkg::B_STBY] && !s.cfg[uc2_pkg::C_WAKE] && rxb.idle
       && !(wr && widx == (AW-2)'(uc2_pkg::CTRL_IDX))) |=> !s.ctrl[uc2_pkg::B_STBY])
      else $error("standby not cleared on quiet line");
   AST_BRK_Q: assert property (@(posedge pclk) disable iff (!presetn)
      (wr && widx == (AW-2)'(uc2_pkg::CTRL_IDX) && !s.ctrl[uc2_pkg::B_BRK]
       && pwdata[uc2_pkg::B_BRK] && pwdata[uc2_pkg::B_TXON])
      |=> (s.brk_pend || s.st == uc2_pkg::TX_BRK))
      else $error("break not queued");
   AST_BRK_LOW: assert property (@(posedge pclk) disable iff (!presetn)
      (s.st == uc2_pkg::TX_BRK) |-> !txd_out)
      else $error("break line not low");
   AST_CTRL_WR: assert property (@(posedge pclk) disable iff (!presetn)
      (wr && widx == (AW-2)'(uc2_pkg::CTRL_IDX)) |=> (s.ctrl == $past(pwdata[7:0])))
      else $error("control write not stored");
endmodule : uc2_top
`default_nettype wire

// [uc2_remote.sv]
// remote serial device facing the transmit and receive lines
`timescale 1ns/1ps
`default_nettype none
module uc2_remote #(
   parameter int BIT = 8
) (
   input  wire logic pclk, // time base for bit periods
   input  wire logic txd,  // transmit line as seen on the wire
   output logic      rxd   // receive line toward the block
);
   logic [7:0] got;
   int         low_len;
   event       got_ev;
   event       low_ev;
   initial rxd = 1'b1;
   // start, eight data bits lsb first, stop; line rests high between frames
   task automatic send(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      @(posedge pclk);
      for (int i = 0; i < 10; i++)
      begin
         rxd <= f[i];
         repeat (BIT) @(posedge pclk);
      end
   endtask : send
   // mid-bit sampling on the falling edge keeps clear of the block's updates
   initial forever
   begin
      @(negedge txd);
      repeat (BIT / 2) @(negedge pclk);
      for (int i = 0; i < 8; i++)
      begin
         repeat (BIT) @(negedge pclk);
         got[i] = txd;
      end
      repeat (BIT) @(negedge pclk);
      if (txd === 1'b1)
         -> got_ev;
      while (txd !== 1'b1)
         @(negedge pclk);
   end
   initial forever
   begin
      @(negedge txd);
      low_len = 0;
      @(negedge pclk);
      while (txd !== 1'b1)
      begin
         low_len++;
         @(negedge pclk);
      end
      -> low_ev;
   end
endmodule : uc2_remote
`default_nettype wire

// [test_uc2_top.sv]
// self-checking bench for the serial port control block
`timescale 1ns/1ps
`default_nettype none
module test_uc2_top;
   localparam int BIT = 8;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic        err_seen;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        irq;
   logic        txd_out;
   logic        txd_oe_n;
   logic        tx_pin_own;
   logic        rxd;
   logic        rxd_pin_own;
   wire         line;
   logic [7:0]  b;
   logic [31:0] rq[$];
   logic [31:0] txq[$];
   int          failures;
   int          tests_run;
   int          cyc;
   int          n;
   // released transmit pin floats to its pull-up
   assign line = txd_oe_n ? 1'b1 : txd_out;
   uc2_top #(.AW(12), .BIT_CYCLES(BIT)) uc2_top_i (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .txd_in(line),
      .txd_out(txd_out), .txd_oe_n(txd_oe_n), .tx_pin_own(tx_pin_own), .rxd_in(rxd),
      .rxd_pin_own(rxd_pin_own));
   uc2_remote #(.BIT(BIT)) uc2_remote_i (.pclk(pclk), .txd(line), .rxd(rxd));
   initial
   begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : close_out
   // for a read, d is the value expected back
   task automatic rw(input logic wr, input logic [7:0] idx, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {2'b00, idx, 2'b00};
      pwdata  <= d;
      if (!wr)
         rq.push_back(d);
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      err_seen = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(negedge pclk);
   endtask : rw
   always @(posedge pclk)
      if (psel && penable && pready && !pwrite)
         check(prdata, rq.size() > 0 ? rq.pop_front() : 32'hdead0000);
   always @(uc2_remote_i.got_ev)
      check({24'h0, uc2_remote_i.got}, txq.size() > 0 ? txq.pop_front() : 32'hffff);
   // ceiling is over ten times the roughly fifteen hundred cycles the sequence needs
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         failures++;
         close_out();
      end
   end
   initial
   begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      void'($urandom(29878));
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rw(0, uc2_pkg::CTRL_IDX, 32'h00);
      check(32'({irq, tx_pin_own, rxd_pin_own, txd_oe_n}), 32'h1);
      rw(0, uc2_pkg::STAT_IDX, 32'hc0);
      rw(0, 8'h3f, 32'h0);
      check(32'(err_seen), 32'h1);
      check(32'(pready), 32'h1);
      for (int i = 0; i < 5; i++)
      begin
         b = (i < 3) ? (8'h80 >> i) : (8'($urandom) & 8'hf0);
         rw(1, uc2_pkg::CTRL_IDX, 32'(b));
         rw(0, uc2_pkg::CTRL_IDX, 32'(b));
         check(32'(irq), 32'(b[7] | b[6]));
      end
      $display("enables done");
      rw(1, uc2_pkg::CTRL_IDX, 32'h04);
      check(32'(rxd_pin_own), 32'h1);
      rw(1, uc2_pkg::CFG_IDX, 32'h01);
      check(32'(rxd_pin_own), 32'h0);
      rw(1, uc2_pkg::CFG_IDX, 32'h00);
      rw(1, uc2_pkg::CTRL_IDX, 32'h24);
      b = 8'($urandom);
      check(32'(irq), 32'h0);
      uc2_remote_i.send(b);
      while (irq !== 1'b1)
         @(posedge pclk);
      rw(0, uc2_pkg::DATA_IDX, 32'(b));
      check(32'(irq), 32'h0);
      rw(1, uc2_pkg::CTRL_IDX, 32'h14);
      while (irq !== 1'b1)
         @(posedge pclk);
      rw(0, uc2_pkg::STAT_IDX, 32'hd0);
      rw(0, uc2_pkg::DATA_IDX, 32'(b));
      check(32'(irq), 32'h0);
      $display("receive done");
      rw(1, uc2_pkg::CFG_IDX, 32'h20);
      rw(1, uc2_pkg::CTRL_IDX, 32'h06);
      uc2_remote_i.send(8'h12);
      rw(0, uc2_pkg::CTRL_IDX, 32'h06);
      uc2_remote_i.send(8'h92);
      rw(0, uc2_pkg::CTRL_IDX, 32'h04);
      // quiet line wakeup: the character is dropped, the quiet line after it wakes
      rw(1, uc2_pkg::CFG_IDX, 32'h00);
      rw(1, uc2_pkg::CTRL_IDX, 32'h06);
      uc2_remote_i.send(8'h55);
      repeat (12 * BIT) @(posedge pclk);
      rw(0, uc2_pkg::CTRL_IDX, 32'h04);
      $display("standby done");
      rw(1, uc2_pkg::CFG_IDX, 32'h00);
      rw(1, uc2_pkg::CTRL_IDX, 32'h08);
      check(32'({tx_pin_own, txd_oe_n}), 32'h2);
      b = 8'($urandom);
      txq.push_back(32'(b));
      rw(1, uc2_pkg::DATA_IDX, 32'(b));
      rw(1, uc2_pkg::CTRL_IDX, 32'h00);
      check(32'(tx_pin_own), 32'h1);
      while (tx_pin_own !== 1'b0)
         @(posedge pclk);
      @(negedge pclk);
      check(32'(txd_oe_n), 32'h1);
      check(32'(txq.size()), 32'h0);
      // off then on during an idle character queues a second one, so tx done stays low
      rw(1, uc2_pkg::CTRL_IDX, 32'h08);
      rw(1, uc2_pkg::CTRL_IDX, 32'h00);
      rw(1, uc2_pkg::CTRL_IDX, 32'h48);
      repeat (10 * BIT) @(posedge pclk);
      @(negedge pclk);
      check(32'(irq), 32'h0);
      while (irq !== 1'b1)
         @(posedge pclk);
      rw(1, uc2_pkg::CTRL_IDX, 32'h00);
      while (tx_pin_own !== 1'b0)
         @(posedge pclk);
      $display("transmit done");
      for (int lb = 0; lb < 2; lb++)
      begin
         rw(1, uc2_pkg::CFG_IDX, 32'(lb << 3));
         n = BIT * int'(lb ? uc2_pkg::LBRK_BITS : uc2_pkg::BRK_BITS);
         rw(1, uc2_pkg::CTRL_IDX, 32'h09);
         // the long pass holds break_send past one break so a second one follows
         if (lb == 1)
            repeat (n + BIT) @(posedge pclk);
         rw(1, uc2_pkg::CTRL_IDX, 32'h08);
         do
            @(uc2_remote_i.low_ev);
         while (uc2_remote_i.low_len < n);
         // a held break reloads in place and shows as a run of two lengths
         check(32'(uc2_remote_i.low_len % n), 32'h0);
         check(32'(uc2_remote_i.low_len), 32'((lb + 1) * n));
         rw(1, uc2_pkg::CTRL_IDX, 32'h00);
         while (tx_pin_own !== 1'b0)
            @(posedge pclk);
      end
      $display("break done");
      rw(1, uc2_pkg::CFG_IDX, 32'h07);
      rw(1, uc2_pkg::CTRL_IDX, 32'h0c);
      repeat (12 * BIT) @(posedge pclk);
      @(negedge pclk);
      check(32'({txd_oe_n, rxd_pin_own}), 32'h0);
      rw(1, uc2_pkg::CFG_IDX, 32'h03);
      check(32'(txd_oe_n), 32'h1);
      $display("single wire done");
      close_out();
   end
endmodule : test_uc2_top
`default_nettype wire
